// File: verilog/led_sink_level_registers.sv
// Level code register bank for the grouped backlight and LED sink channels 2 and 3
// Function
// - The group level register keeps a 6-bit group level code in bits 5 to 0.
// - A channel in the backlight group takes the group level code as its level.
// - Bit 7 of the channel-2 register puts channel 2 in the group when 1, solo when 0.
// - Bit 7 of the channel-3 register puts channel 3 in the group when 1, solo when 0.
// - Bits 5 to 0 of the channel-2 register are its solo level code.
// - Channel 2's solo code is ignored in the group but kept and readable.
// - Channel 3's solo code in bits 5 to 0 is ignored while it is in the group.
// - Each 6-bit code picks one of 64 square-law steps, 0 is off and all ones full scale.
// - The group enable turns the whole backlight group on or off.
// - A solo enable switches its sink but has no effect while in the group.
`include "led_level_consts.svh"
module led_sink_level_registers (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire led_level_pkg::reg_byte_t reg_wdata,
  output led_level_pkg::reg_byte_t reg_rdata,
  input wire logic group_enable,
  input wire logic ch2_solo_enable,
  input wire logic ch3_solo_enable,
  output led_level_pkg::level_code_t group_sink_code,
  output logic group_sink_on,
  output led_level_pkg::level_code_t ch2_sink_code,
  output logic ch2_sink_on,
  output led_level_pkg::level_code_t ch3_sink_code,
  output logic ch3_sink_on
);
  // Stored fields: level codes and group selects
  led_level_pkg::level_code_t group_level_code_reg, group_level_code_next;
  led_level_pkg::level_code_t ch2_solo_level_code_reg, ch2_solo_level_code_next;
  led_level_pkg::level_code_t ch3_solo_level_code_reg, ch3_solo_level_code_next;
  logic ch2_group_select_reg, ch2_group_select_next;
  logic ch3_group_select_reg, ch3_group_select_next;
  // Registered readback byte
  led_level_pkg::reg_byte_t reg_rdata_reg, reg_rdata_next;
  // Registered drive for each sink
  led_level_pkg::level_code_t grp_code_reg, grp_code_next;
  logic grp_on_reg, grp_on_next;
  led_level_pkg::level_code_t c2_code_reg, c2_code_next;
  logic c2_on_reg, c2_on_next;
  led_level_pkg::level_code_t c3_code_reg, c3_code_next;
  logic c3_on_reg, c3_on_next;
  // Address decode and per-channel selection
  logic [2:0] reg_hit, wr_hit;
  led_level_pkg::level_code_t c2_sel_code, c3_sel_code;
  logic c2_sel_on, c3_sel_on;

  // One-hot decode of the level registers; any other address hits nothing
  function automatic logic [2:0] decode_reg(input logic [7:0] addr);
    case (addr)
      `GROUP_LEVEL_OFFSET: decode_reg = 3'h1;
      `CH2_LEVEL_OFFSET: decode_reg = 3'h2;
      `CH3_LEVEL_OFFSET: decode_reg = 3'h4;
      default: decode_reg = 3'h0;
    endcase
  endfunction

  // Packs a channel register for readback; bit 6 always zero
  function automatic led_level_pkg::reg_byte_t pack_channel(
    input logic sel, input led_level_pkg::level_code_t code);
    pack_channel = {sel, 1'h0, code};
  endfunction

  // Packs the group register; bits 7 to 6 always zero
  function automatic led_level_pkg::reg_byte_t pack_group(
    input led_level_pkg::level_code_t code);
    pack_group = {2'h0, code};
  endfunction

  // Zero code while off, so a dark sink never holds a stale level
  function automatic led_level_pkg::level_code_t gate_code(
    input logic on, input led_level_pkg::level_code_t code);
    gate_code = on ? code : `LEVEL_CODE_ZERO;
  endfunction

  // Decode once; the write path also needs the strobe
  always_comb begin
    reg_hit = decode_reg(reg_addr);
    wr_hit = reg_wr ? reg_hit : 3'h0;
  end

  // Register writes; only defined fields are stored, the rest is dropped
  always_comb begin
    group_level_code_next = group_level_code_reg;
    ch2_solo_level_code_next = ch2_solo_level_code_reg;
    ch3_solo_level_code_next = ch3_solo_level_code_reg;
    ch2_group_select_next = ch2_group_select_reg;
    ch3_group_select_next = ch3_group_select_reg;
    if (wr_hit[0]) begin
      group_level_code_next = reg_wdata[`LEVEL_CODE_MSB:0];
    end
    if (wr_hit[1]) begin
      ch2_group_select_next = reg_wdata[`GROUP_SELECT_BIT];
      ch2_solo_level_code_next = reg_wdata[`LEVEL_CODE_MSB:0];
    end
    if (wr_hit[2]) begin
      ch3_group_select_next = reg_wdata[`GROUP_SELECT_BIT];
      ch3_solo_level_code_next = reg_wdata[`LEVEL_CODE_MSB:0];
    end
  end

  // Settings registers; sync reset leaves every sink at zero and solo
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      group_level_code_reg <= `LEVEL_CODE_RESET;
      ch2_solo_level_code_reg <= `LEVEL_CODE_RESET;
      ch3_solo_level_code_reg <= `LEVEL_CODE_RESET;
      ch2_group_select_reg <= `GROUP_SELECT_RESET;
      ch3_group_select_reg <= `GROUP_SELECT_RESET;
    end else begin
      group_level_code_reg <= group_level_code_next;
      ch2_solo_level_code_reg <= ch2_solo_level_code_next;
      ch3_solo_level_code_reg <= ch3_solo_level_code_next;
      ch2_group_select_reg <= ch2_group_select_next;
      ch3_group_select_reg <= ch3_group_select_next;
    end
  end

  // Readback keeps solo codes visible even while a channel is in the group
  always_comb begin
    reg_rdata_next = `REG_READ_ZERO;
    if (reg_hit[0]) begin
      reg_rdata_next = pack_group(group_level_code_reg);
    end
    if (reg_hit[1]) begin
      reg_rdata_next = pack_channel(ch2_group_select_reg, ch2_solo_level_code_reg);
    end
    if (reg_hit[2]) begin
      reg_rdata_next = pack_channel(ch3_group_select_reg, ch3_solo_level_code_reg);
    end
  end

  // Read data register; reads have no strobe, so it simply tracks the address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_reg <= `REG_READ_ZERO;
    end else begin
      reg_rdata_reg <= reg_rdata_next;
    end
  end

  // Per-channel code choice, shared with the group code
  sink_level_select u_ch2 (
    .group_select(ch2_group_select_reg),
    .group_enable(group_enable),
    .solo_enable(ch2_solo_enable),
    .group_code(group_level_code_reg),
    .solo_code(ch2_solo_level_code_reg),
    .sink_code(c2_sel_code),
    .sink_on(c2_sel_on)
  );
  sink_level_select u_ch3 (
    .group_select(ch3_group_select_reg),
    .group_enable(group_enable),
    .solo_enable(ch3_solo_enable),
    .group_code(group_level_code_reg),
    .solo_code(ch3_solo_level_code_reg),
    .sink_code(c3_sel_code),
    .sink_on(c3_sel_on)
  );

  // Group sink drive follows the group enable one edge later
  always_comb begin
    grp_on_next = group_enable;
    grp_code_next = gate_code(group_enable, group_level_code_reg);
  end

  // Group sink registers; registering keeps decode glitches off the analog side
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      grp_on_reg <= `SINK_OFF;
      grp_code_reg <= `LEVEL_CODE_ZERO;
    end else begin
      grp_on_reg <= grp_on_next;
      grp_code_reg <= grp_code_next;
    end
  end

  // Channel 2 sink drive; member or solo choice made by the selector
  always_comb begin
    c2_on_next = c2_sel_on;
    c2_code_next = gate_code(c2_sel_on, c2_sel_code);
  end

  // Channel 2 sink registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      c2_on_reg <= `SINK_OFF;
      c2_code_reg <= `LEVEL_CODE_ZERO;
    end else begin
      c2_on_reg <= c2_on_next;
      c2_code_reg <= c2_code_next;
    end
  end

  // Channel 3 sink drive; member or solo choice made by the selector
  always_comb begin
    c3_on_next = c3_sel_on;
    c3_code_next = gate_code(c3_sel_on, c3_sel_code);
  end

  // Channel 3 sink registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      c3_on_reg <= `SINK_OFF;
      c3_code_reg <= `LEVEL_CODE_ZERO;
    end else begin
      c3_on_reg <= c3_on_next;
      c3_code_reg <= c3_code_next;
    end
  end

  // Outputs come straight from the readback and drive registers
  assign reg_rdata = reg_rdata_reg;
  assign group_sink_code = grp_code_reg;
  assign group_sink_on = grp_on_reg;
  assign ch2_sink_code = c2_code_reg;
  assign ch2_sink_on = c2_on_reg;
  assign ch3_sink_code = c3_code_reg;
  assign ch3_sink_on = c3_on_reg;
endmodule

// File: verilog/led_level_consts.svh
// Register offsets, field positions and reset values for the LED sink level bank
`ifndef LED_LEVEL_CONSTS_SVH
`define LED_LEVEL_CONSTS_SVH
`define GROUP_LEVEL_OFFSET 8'h28
`define CH2_LEVEL_OFFSET 8'h29
`define CH3_LEVEL_OFFSET 8'h2a
`define GROUP_SELECT_BIT 7
`define LEVEL_CODE_MSB 5
`define LEVEL_CODE_RESET 6'h00
`define LEVEL_CODE_ZERO 6'h00
`define REG_READ_ZERO 8'h00
`define GROUP_SELECT_RESET 1'h0
`define SINK_OFF 1'h0
`endif

// File: verilog/led_level_pkg.sv
// Types shared by the LED sink level bank
package led_level_pkg;
  typedef logic [5:0] level_code_t;
  typedef logic [7:0] reg_byte_t;
endpackage

// File: verilog/sink_level_select.sv
// Picks the level code that drives one sink channel
module sink_level_select (
  input wire logic group_select,
  input wire logic group_enable,
  input wire logic solo_enable,
  input wire led_level_pkg::level_code_t group_code,
  input wire led_level_pkg::level_code_t solo_code,
  output led_level_pkg::level_code_t sink_code,
  output logic sink_on
);
  // Group members follow the shared code; solo code and enable then ignored
  always_comb begin
    if (group_select) begin
      sink_code = group_code;
      sink_on = group_enable;
    end else begin
      sink_code = solo_code;
      sink_on = solo_enable;
    end
  end
endmodule

// File: verification/led_sink_level_props.sv
// Port checks for the LED sink level register bank
module led_sink_level_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire led_level_pkg::reg_byte_t reg_rdata,
  input wire logic group_enable,
  input wire logic ch2_solo_enable,
  input wire led_level_pkg::level_code_t group_sink_code,
  input wire logic group_sink_on,
  input wire led_level_pkg::level_code_t ch2_sink_code,
  input wire logic ch2_sink_on,
  input wire led_level_pkg::level_code_t ch3_sink_code,
  input wire logic ch3_sink_on
);
  logic live_reg;
  logic [7:0] addr_reg;
  // Previous-edge view; avoids $past reaching back into reset
  always_ff @(posedge clk) begin
    live_reg <= rst_n;
    addr_reg <= reg_addr;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  chk_group_on: assert property (live_reg |-> group_sink_on == $past(group_enable))
    else $error("group on wrong");
  chk_group_off_zero: assert property (!group_sink_on |-> group_sink_code == 6'h00)
    else $error("group code not zero");
  chk_ch3_off_zero: assert property (!ch3_sink_on |-> ch3_sink_code == 6'h00)
    else $error("ch3 code not zero");
  chk_unused_bit: assert property (reg_rdata[6] == 1'h0)
    else $error("bit 6 set");
  chk_unmapped_read: assert property (live_reg && !(addr_reg inside {[8'h28:8'h2a]})
    |-> reg_rdata == 8'h00)
    else $error("unmapped read");
  chk_ch2_member: assert property (live_reg && addr_reg == 8'h29 && reg_rdata[7] |->
    {ch2_sink_on, ch2_sink_code} == {group_sink_on, group_sink_code})
    else $error("ch2 not following group");
  chk_ch2_solo: assert property (live_reg && addr_reg == 8'h29 && !reg_rdata[7] |->
    ch2_sink_on == $past(ch2_solo_enable) &&
    ch2_sink_code == (ch2_sink_on ? reg_rdata[5:0] : 6'h00))
    else $error("ch2 solo wrong");
  chk_ch3_member: assert property (live_reg && addr_reg == 8'h2a && reg_rdata[7] |->
    ch3_sink_code == group_sink_code)
    else $error("ch3 not following group");
  chk_reset_zero: assert property (!live_reg |-> reg_rdata == 8'h00 &&
    ch2_sink_code == 6'h00 && ch3_sink_code == 6'h00 && group_sink_code == 6'h00)
    else $error("not zero after reset");
endmodule
bind led_sink_level_registers led_sink_level_props i_props (.clk, .rst_n, .reg_addr,
  .reg_rdata, .group_enable, .ch2_solo_enable, .group_sink_code, .group_sink_on,
  .ch2_sink_code, .ch2_sink_on, .ch3_sink_code, .ch3_sink_on);

// File: verification/led_sink_level_registers_tb.sv
// Self-checking bench for the LED sink level register bank
module led_sink_level_registers_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, group_enable = 1'h0;
  logic ch2_solo_enable = 1'h0, ch3_solo_enable = 1'h0, group_sink_on, ch2_sink_on, ch3_sink_on;
  logic [7:0] reg_addr = 8'h00;
  led_level_pkg::reg_byte_t reg_wdata = 8'h00, reg_rdata;
  led_level_pkg::level_code_t group_sink_code, ch2_sink_code, ch3_sink_code;
  logic [7:0] m [3] = '{8'h00, 8'h00, 8'h00};
  logic [15:0] corner [7] = '{16'h30ff, 16'h28ff, 16'h29ff, 16'h2aff, 16'h297f, 16'h2a40, 16'h2800};
  int error_cnt = 0, n_tests = 0, cyc = 0;
  led_sink_level_registers i_dut (.clk, .rst_n, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
    .group_enable, .ch2_solo_enable, .ch3_solo_enable, .group_sink_code, .group_sink_on,
    .ch2_sink_code, .ch2_sink_on, .ch3_sink_code, .ch3_sink_on);
  initial begin
    forever #20 clk = ~clk;
  end
  // Expected {0, on, code}; code held at zero while the sink is off
  function automatic logic [7:0] sink(logic [7:0] r, logic solo_en);
    logic on;
    on = r[7] ? group_enable : solo_en;
    return {1'h0, on, on ? (r[7] ? m[0][5:0] : r[5:0]) : 6'h00};
  endfunction
  // Seen {0, on, code} of one sink, widened to the compare width
  function automatic logic [7:0] drv(logic on, led_level_pkg::level_code_t code);
    return {1'h0, on, code};
  endfunction
  task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Write with fresh random enables, then read back and check every sink
  task automatic step(logic [7:0] wa, logic [7:0] wd);
    logic hit;
    hit = wa inside {[8'h28:8'h2a]};
    @(negedge clk);
    reg_addr = wa;
    reg_wdata = wd;
    reg_wr = 1'h1;
    {group_enable, ch2_solo_enable, ch3_solo_enable} = 3'($urandom);
    if (hit) m[wa[1:0]] = wd & (wa == 8'h28 ? 8'h3f : 8'hbf);
    @(negedge clk);
    reg_wr = 1'h0;
    @(negedge clk);
    chk("rdata", reg_rdata, hit ? m[wa[1:0]] : 8'h00);
    chk("group", drv(group_sink_on, group_sink_code), sink(8'h80, 1'h0));
    chk("ch2", drv(ch2_sink_on, ch2_sink_code), sink(m[1], ch2_solo_enable));
    chk("ch3", drv(ch3_sink_on, ch3_sink_code), sink(m[2], ch3_solo_enable));
  endtask
  // Hang guard; the run needs a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(31));
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_n = 1'h1;
    foreach (corner[i]) step(corner[i][15:8], corner[i][7:0]);
    step(8'h29, 8'hff);
    // Mid-run reset with a member loaded; every field must come back zero
    rst_n = 1'h0;
    m = '{8'h00, 8'h00, 8'h00};
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    step(8'h30, 8'h00);
    repeat (60) step(8'h27 + 8'($urandom_range(4)), 8'($urandom));
    tally_and_finish();
  end
endmodule
